/* File: hw/tsr_pkg.sv */
package tsr_pkg;
   localparam int ADDR_W = 8;
   localparam logic [7:0] OFS_ANALOG = 8'h00;
   localparam logic [7:0] OFS_LEVEL_A = 8'h04;
   localparam logic [7:0] OFS_LEVEL_B = 8'h08;
   localparam logic [7:0] OFS_SEL_ONE = 8'h0c;
   localparam logic [7:0] OFS_SEL_TWO = 8'h10;
   localparam logic [7:0] OFS_CMD = 8'h14;
   localparam logic [7:0] OFS_STATUS = 8'h18;
   localparam logic [7:0] RST_VAL = 8'h00;
   localparam int CMD_SEND_BIT = 0;
   localparam int CMD_STOP_BIT = 1;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [4:0] GRP_RECEIVER = 5'h07;
   localparam logic [4:0] GRP_OSC = 5'h0d;
   localparam logic [1:0] DIV_LAST = 2'h3;
   localparam logic [3:0] SRC_HIZ = 4'h0;
   localparam logic [3:0] SRC_LEVEL = 4'h1;
   localparam logic [3:0] SRC_CORR = 4'h2;
   localparam logic [3:0] SRC_MIN = 4'h4;
   localparam logic [3:0] SRC_ADC_I = 4'h5;
   localparam logic [3:0] SRC_ADC_Q = 4'h6;
   localparam logic [3:0] SRC_HIGH = 4'ha;
   localparam logic [3:0] SRC_LOW = 4'hb;
   localparam logic [3:0] SRC_TX_ACT = 4'hc;
   localparam logic [3:0] SRC_RX_ACT = 4'hd;
   localparam logic [3:0] SRC_SUBC = 4'he;
   localparam logic [3:0] SRC_BUS_BIT = 4'hf;
   localparam logic [14:0] PRBS_SEED = 15'h7fff;
   typedef enum logic [2:0] {
      KIND_IDLE, KIND_START, KIND_DATA, KIND_PARITY, KIND_CRC
   } tsr_kind_e;
   typedef enum logic [1:0] {
      RATE_106, RATE_212, RATE_424, RATE_848
   } tsr_rate_e;
   typedef enum logic [1:0] {PRBS_OFF, PRBS_9, PRBS_15} tsr_mode_e;
   typedef enum logic [1:0] {PS_IDLE = 2'b00, PS_RUN = 2'b01} tsr_prbs_e;
   typedef struct packed {
      logic data; logic coll; logic valid; logic over; logic rst;
   } tsr_rx_s;
   typedef struct packed {
      logic [5:0] corr; logic [5:0] minlvl;
      logic [5:0] adc_i; logic [5:0] adc_q;
   } tsr_ana_s;
   typedef struct packed {
      logic oe; logic analog; logic dig; logic [5:0] level;
   } tsr_aux_s;
   typedef struct packed {
      logic raw_s1; logic raw_s2; logic raw_prev;
      logic stb_s1; logic stb_s2;
      logic [1:0] div_cnt; logic div8;
      logic [7:0] analog_test; logic [7:0] level_a; logic [7:0] level_b;
      logic [7:0] sel_one; logic [7:0] sel_two;
      tsr_prbs_e prbs_st; logic prbs_on;
      logic [14:0] lfsr; logic prbs_bit;
      logic tx_act; logic rx_act; logic [5:0] bus; logic tbit;
      tsr_aux_s aux_a; tsr_aux_s aux_b;
      logic aw_got; logic w_got; logic [7:0] waddr;
      logic [7:0] wdata; logic wstb;
      logic awrdy; logic wrdy; logic bvalid; logic [1:0] bresp;
      logic arrdy; logic rvalid; logic [7:0] rdata; logic [1:0] rresp;
   } tsr_state_s;
endpackage

/* File: hw/tsr_router.sv */
`timescale 1ns/100ps
// What this block does
// - Group 0Dh: line 6 osc stable, line 5 osc/8, line 2 raw osc.
// - Two independent 4-bit aux source selects in one control register.
// - Codes 0 hi-Z, 1 test level, 2/4/5/6 analog signals, others reserved.
// - Codes A high, B low, C tx flag, D rx flag, E subcarrier, F bus bit.
// - Control 11h puts test level A on pin A, B on pin B.
// - Upper nibble selects pin A, lower nibble pin B.
// - Test levels take 00h to 3Fh; analog output follows value.
// - At 106 kBd rx flag high on data, parity, CRC; low on start.
// - At 106 kBd tx flag high on start, data, parity, CRC.
// - At higher rates rx flag high only on data and CRC.
// - At higher rates tx flag high only on data and CRC.
// - Group 07h routes receiver signals to lines 2 to 6; line 1 stays low.
// - 3-bit selector picks bus line for bus bit; 6 picks line 6.
// - PRBS9 and PRBS15 sequences chosen in test select two.
// - Send command starts the selected sequence.
// - Framing bits inserted automatically during sequence sending.
// - Receiver group: data, collision (106 only), valid, stop, reset.
// - 5-bit group select field in test select two.
module tsr_router (
   input wire logic SYS_CLK_IN,
   input wire logic RESETN_IN,
   input wire logic CE_IN,
   input wire logic [7:0] S_AXI_AWADDR_IN,
   input wire logic S_AXI_AWVALID_IN,
   output logic S_AXI_AWREADY_OUT,
   input wire logic [31:0] S_AXI_WDATA_IN,
   input wire logic [3:0] S_AXI_WSTRB_IN,
   input wire logic S_AXI_WVALID_IN,
   output logic S_AXI_WREADY_OUT,
   output logic [1:0] S_AXI_BRESP_OUT,
   output logic S_AXI_BVALID_OUT,
   input wire logic S_AXI_BREADY_IN,
   input wire logic [7:0] S_AXI_ARADDR_IN,
   input wire logic S_AXI_ARVALID_IN,
   output logic S_AXI_ARREADY_OUT,
   output logic [31:0] S_AXI_RDATA_OUT,
   output logic [1:0] S_AXI_RRESP_OUT,
   output logic S_AXI_RVALID_OUT,
   input wire logic S_AXI_RREADY_IN,
   input wire logic OSC_RAW_IN,
   input wire logic OSC_STABLE_IN,
   input wire tsr_pkg::tsr_rx_s RX_SIG_IN,
   input wire tsr_pkg::tsr_ana_s ANA_IN,
   input wire logic SUBCARRIER_IN,
   input wire tsr_pkg::tsr_kind_e TX_KIND_IN,
   input wire tsr_pkg::tsr_kind_e RX_KIND_IN,
   input wire tsr_pkg::tsr_rate_e RATE_IN,
   input wire logic TX_BIT_TAKE_IN,
   output logic [5:0] TEST_BUS_OUT,
   output tsr_pkg::tsr_aux_s AUX_A_OUT,
   output tsr_pkg::tsr_aux_s AUX_B_OUT,
   output logic PRBS_ACTIVE_OUT,
   output logic PRBS_BIT_OUT
);
   tsr_pkg::tsr_state_s q;
   tsr_pkg::tsr_state_s d;
   logic wr_fire;
   logic cmd_send;
   logic cmd_stop;
   logic r106;
   tsr_pkg::tsr_mode_e mode;

   initial begin
      if (tsr_pkg::ADDR_W != 8) begin
         $error("tsr_router supports an 8-bit address only");
      end
   end

   function automatic logic mapped(input logic [7:0] a);
      mapped = (a == tsr_pkg::OFS_ANALOG) || (a == tsr_pkg::OFS_LEVEL_A) ||
         (a == tsr_pkg::OFS_LEVEL_B) || (a == tsr_pkg::OFS_SEL_ONE) ||
         (a == tsr_pkg::OFS_SEL_TWO) || (a == tsr_pkg::OFS_CMD) ||
         (a == tsr_pkg::OFS_STATUS);
   endfunction

   // Per-pin source mux, used for both aux pins
   function automatic tsr_pkg::tsr_aux_s aux_mux(
      input logic [3:0] code, input logic [7:0] lvl,
      input tsr_pkg::tsr_ana_s ana, input logic txa, input logic rxa,
      input logic subc, input logic tbit);
      tsr_pkg::tsr_aux_s r;
      r = '0;
      case (code)
         tsr_pkg::SRC_LEVEL: r = '{1'b1, 1'b1, 1'b0, lvl[5:0]};
         tsr_pkg::SRC_CORR: r = '{1'b1, 1'b1, 1'b0, ana.corr};
         tsr_pkg::SRC_MIN: r = '{1'b1, 1'b1, 1'b0, ana.minlvl};
         tsr_pkg::SRC_ADC_I: r = '{1'b1, 1'b1, 1'b0, ana.adc_i};
         tsr_pkg::SRC_ADC_Q: r = '{1'b1, 1'b1, 1'b0, ana.adc_q};
         tsr_pkg::SRC_HIGH: r = '{1'b1, 1'b0, 1'b1, 6'h00};
         tsr_pkg::SRC_LOW: r = '{1'b1, 1'b0, 1'b0, 6'h00};
         tsr_pkg::SRC_TX_ACT: r = '{1'b1, 1'b0, txa, 6'h00};
         tsr_pkg::SRC_RX_ACT: r = '{1'b1, 1'b0, rxa, 6'h00};
         tsr_pkg::SRC_SUBC: r = '{1'b1, 1'b0, subc, 6'h00};
         tsr_pkg::SRC_BUS_BIT: r = '{1'b1, 1'b0, tbit, 6'h00};
         default: r = '0;
      endcase
      aux_mux = r;
   endfunction

   function automatic logic bus_pick(input logic [2:0] sel,
      input logic [5:0] bus);
      if ((sel >= 3'h1) && (sel <= 3'h6)) begin
         bus_pick = bus[sel - 3'h1];
      end else begin
         bus_pick = 1'b0;
      end
   endfunction

   function automatic logic [14:0] prbs_step(input logic [14:0] l,
      input tsr_pkg::tsr_mode_e m);
      if (m == tsr_pkg::PRBS_9) begin
         prbs_step = {l[13:0], l[8] ^ l[4]};
      end else begin
         prbs_step = {l[13:0], l[14] ^ l[13]};
      end
   endfunction

   assign r106 = (RATE_IN == tsr_pkg::RATE_106);
   assign mode = tsr_pkg::tsr_mode_e'(q.sel_two[6:5]);
   assign wr_fire = q.aw_got && q.w_got && !q.bvalid;
   assign cmd_send = wr_fire && (q.waddr == tsr_pkg::OFS_CMD) && q.wstb &&
      q.wdata[tsr_pkg::CMD_SEND_BIT];
   assign cmd_stop = wr_fire && (q.waddr == tsr_pkg::OFS_CMD) && q.wstb &&
      q.wdata[tsr_pkg::CMD_STOP_BIT];

   always_comb begin
      d = q;
      if (CE_IN) begin
         d.raw_s1 = OSC_RAW_IN;
         d.raw_s2 = q.raw_s1;
         d.raw_prev = q.raw_s2;
         d.stb_s1 = OSC_STABLE_IN;
         d.stb_s2 = q.stb_s1;
         // Divide by 8: toggle every fourth rising edge
         if (q.raw_s2 && !q.raw_prev) begin
            d.div_cnt = q.div_cnt + 2'h1;
            if (q.div_cnt == tsr_pkg::DIV_LAST) begin
               d.div8 = !q.div8;
            end
         end
         case (RX_KIND_IN)
            tsr_pkg::KIND_DATA, tsr_pkg::KIND_CRC: d.rx_act = 1'b1;
            tsr_pkg::KIND_PARITY: d.rx_act = r106;
            default: d.rx_act = 1'b0;
         endcase
         case (TX_KIND_IN)
            tsr_pkg::KIND_DATA, tsr_pkg::KIND_CRC: d.tx_act = 1'b1;
            tsr_pkg::KIND_START, tsr_pkg::KIND_PARITY: d.tx_act = r106;
            default: d.tx_act = 1'b0;
         endcase
         case (q.sel_two[4:0])
            tsr_pkg::GRP_RECEIVER: d.bus = {RX_SIG_IN.data,
               RX_SIG_IN.coll && r106, RX_SIG_IN.valid, RX_SIG_IN.over,
               RX_SIG_IN.rst, 1'b0};
            tsr_pkg::GRP_OSC: d.bus = {q.stb_s2, q.div8, 2'b00,
               q.raw_s2, 1'b0};
            default: d.bus = 6'h00;
         endcase
         d.tbit = bus_pick(q.sel_one[2:0], q.bus);
         d.aux_a = aux_mux(q.analog_test[7:4], q.level_a, ANA_IN, q.tx_act,
            q.rx_act, SUBCARRIER_IN, q.tbit);
         d.aux_b = aux_mux(q.analog_test[3:0], q.level_b, ANA_IN, q.tx_act,
            q.rx_act, SUBCARRIER_IN, q.tbit);
         // Sequence generator; framer adds preamble, sync, start, parity
         case (q.prbs_st)
            tsr_pkg::PS_IDLE: begin
               if (cmd_send && (mode != tsr_pkg::PRBS_OFF)) begin
                  d.prbs_st = tsr_pkg::PS_RUN;
                  d.lfsr = tsr_pkg::PRBS_SEED;
                  d.prbs_bit = 1'b1;
               end
            end
            tsr_pkg::PS_RUN: begin
               if (cmd_stop || (mode == tsr_pkg::PRBS_OFF)) begin
                  d.prbs_st = tsr_pkg::PS_IDLE;
               end else if (TX_BIT_TAKE_IN) begin
                  d.lfsr = prbs_step(q.lfsr, mode);
                  d.prbs_bit = (mode == tsr_pkg::PRBS_9) ? q.lfsr[7] :
                     q.lfsr[13];
               end
            end
            default: d.prbs_st = tsr_pkg::PS_IDLE;
         endcase
         d.prbs_on = (d.prbs_st == tsr_pkg::PS_RUN);
         // AXI4-Lite write path
         if (q.bvalid && S_AXI_BREADY_IN) begin
            d.bvalid = 1'b0;
         end
         if (S_AXI_AWVALID_IN && q.awrdy) begin
            d.aw_got = 1'b1;
            d.waddr = S_AXI_AWADDR_IN;
         end
         if (S_AXI_WVALID_IN && q.wrdy) begin
            d.w_got = 1'b1;
            d.wdata = S_AXI_WDATA_IN[7:0];
            d.wstb = S_AXI_WSTRB_IN[0];
         end
         if (wr_fire) begin
            d.aw_got = 1'b0;
            d.w_got = 1'b0;
            d.bvalid = 1'b1;
            d.bresp = mapped(q.waddr) ? tsr_pkg::RESP_OKAY :
               tsr_pkg::RESP_SLVERR;
            if (q.wstb) begin
               case (q.waddr)
                  tsr_pkg::OFS_ANALOG: d.analog_test = q.wdata;
                  tsr_pkg::OFS_LEVEL_A: d.level_a = {2'b00, q.wdata[5:0]};
                  tsr_pkg::OFS_LEVEL_B: d.level_b = {2'b00, q.wdata[5:0]};
                  tsr_pkg::OFS_SEL_ONE: d.sel_one = {5'h00, q.wdata[2:0]};
                  tsr_pkg::OFS_SEL_TWO: d.sel_two = {1'b0, q.wdata[6:0]};
                  default: d.sel_one = q.sel_one;
               endcase
            end
         end
         d.awrdy = !d.aw_got && !d.bvalid;
         d.wrdy = !d.w_got && !d.bvalid;
         // AXI4-Lite read path
         if (q.rvalid && S_AXI_RREADY_IN) begin
            d.rvalid = 1'b0;
         end
         if (S_AXI_ARVALID_IN && q.arrdy) begin
            d.rvalid = 1'b1;
            d.rresp = mapped(S_AXI_ARADDR_IN) ? tsr_pkg::RESP_OKAY :
               tsr_pkg::RESP_SLVERR;
            case (S_AXI_ARADDR_IN)
               tsr_pkg::OFS_ANALOG: d.rdata = q.analog_test;
               tsr_pkg::OFS_LEVEL_A: d.rdata = q.level_a;
               tsr_pkg::OFS_LEVEL_B: d.rdata = q.level_b;
               tsr_pkg::OFS_SEL_ONE: d.rdata = q.sel_one;
               tsr_pkg::OFS_SEL_TWO: d.rdata = q.sel_two;
               tsr_pkg::OFS_STATUS: d.rdata = {4'h0, q.tbit, q.rx_act,
                  q.tx_act, q.prbs_on};
               default: d.rdata = 8'h00;
            endcase
         end
         d.arrdy = !d.rvalid;
      end
   end

   always_ff @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         q <= '0;
         q.awrdy <= 1'b1;
         q.wrdy <= 1'b1;
         q.arrdy <= 1'b1;
      end else begin
         q <= d;
      end
   end

   assign S_AXI_AWREADY_OUT = q.awrdy;
   assign S_AXI_WREADY_OUT = q.wrdy;
   assign S_AXI_BRESP_OUT = q.bresp;
   assign S_AXI_BVALID_OUT = q.bvalid;
   assign S_AXI_ARREADY_OUT = q.arrdy;
   assign S_AXI_RDATA_OUT = {24'h000000, q.rdata};
   assign S_AXI_RRESP_OUT = q.rresp;
   assign S_AXI_RVALID_OUT = q.rvalid;
   assign TEST_BUS_OUT = q.bus;
   assign AUX_A_OUT = q.aux_a;
   assign AUX_B_OUT = q.aux_b;
   assign PRBS_ACTIVE_OUT = q.prbs_on;
   assign PRBS_BIT_OUT = q.prbs_bit;

   default clocking cb @(posedge SYS_CLK_IN); endclocking
   default disable iff (!RESETN_IN);

   a_aux_a_hiz: assert property (
      $past(CE_IN) && ($past(q.analog_test[7:4]) == 4'h0) |-> !AUX_A_OUT.oe)
      else $error("aux A driven with code zero");
   a_reserved_hiz: assert property (
      $past(CE_IN) && ($past(q.analog_test[3:0]) inside {4'h3, 4'h7,
      4'h8, 4'h9}) |-> !AUX_B_OUT.oe)
      else $error("aux B driven with reserved code");
   a_aux_force: assert property (
      $past(CE_IN) && ($past(q.analog_test[3:0]) == 4'ha) |->
      AUX_B_OUT.oe && AUX_B_OUT.dig && !AUX_B_OUT.analog)
      else $error("aux B not forced high");
   a_level_follow: assert property (
      $past(CE_IN) && ($past(q.analog_test) == 8'h11) |->
      (AUX_A_OUT.level == $past(q.level_a[5:0])) &&
      (AUX_B_OUT.level == $past(q.level_b[5:0])) && AUX_A_OUT.analog)
      else $error("test levels not on aux pins");
   a_osc_group: assert property (
      $past(CE_IN) && ($past(q.sel_two[4:0]) == 5'h0d) |->
      (TEST_BUS_OUT[5] == $past(q.stb_s2)) &&
      (TEST_BUS_OUT[1] == $past(q.raw_s2)) && (TEST_BUS_OUT[3:2] == 2'b00))
      else $error("oscillator group wrong");
   a_div_eight: assert property (
      $changed(q.div8) |-> ($past(q.div_cnt) == 2'h3))
      else $error("divider toggled off count");
   a_rx_group: assert property (
      $past(CE_IN) && ($past(q.sel_two[4:0]) == 5'h07) |->
      (TEST_BUS_OUT[5] == $past(RX_SIG_IN.data)) &&
      (TEST_BUS_OUT[1] == $past(RX_SIG_IN.rst)))
      else $error("receiver group wrong");
   a_rx_start_low: assert property (
      $past(CE_IN) && ($past(RX_KIND_IN) == tsr_pkg::KIND_START) |->
      !q.rx_act)
      else $error("rx flag high on start bit");
   a_tx_rate: assert property (
      $past(CE_IN) && ($past(TX_KIND_IN) == tsr_pkg::KIND_START) |->
      (q.tx_act == ($past(RATE_IN) == tsr_pkg::RATE_106)))
      else $error("tx flag wrong on start bit");
   a_bus_bit: assert property (
      $past(CE_IN) && ($past(q.sel_one[2:0]) == 3'h6) |->
      (q.tbit == $past(q.bus[5])))
      else $error("bus bit not line 6");
   a_prbs_start: assert property (
      $past(CE_IN) && $past(cmd_send) && !$past(q.prbs_on) &&
      ($past(mode) != tsr_pkg::PRBS_OFF) |-> PRBS_ACTIVE_OUT && PRBS_BIT_OUT)
      else $error("sequence did not start");
   a_prbs9_seq: assert property (
      $past(CE_IN) && $past(q.prbs_on) && $past(TX_BIT_TAKE_IN) &&
      ($past(mode) == tsr_pkg::PRBS_9) && !$past(cmd_stop) |->
      (PRBS_BIT_OUT == $past(q.lfsr[7])))
      else $error("sequence bit wrong");
   c_prbs_run: cover property (PRBS_ACTIVE_OUT && $past(TX_BIT_TAKE_IN));
   c_level_mode: cover property (q.analog_test == 8'h11 && AUX_A_OUT.oe);
   c_bus_bit: cover property (q.sel_two[4:0] == 5'h07 && q.tbit);
   c_tx_rise: cover property ($rose(q.tx_act));
endmodule

/* File: dv/tsr_meter.sv */
`timescale 1ns/100ps
// Bench meter on both aux pins; the pull-down makes a released pin read low
module tsr_meter (
   input wire tsr_pkg::tsr_aux_s a_in,
   input wire tsr_pkg::tsr_aux_s b_in,
   output logic a_dig_out,
   output logic [5:0] a_lvl_out,
   output logic b_dig_out,
   output logic [5:0] b_lvl_out
);
   always_comb begin
      a_dig_out = a_in.oe & ~a_in.analog & a_in.dig;
      a_lvl_out = (a_in.oe & a_in.analog) ? a_in.level : 6'h00;
      b_dig_out = b_in.oe & ~b_in.analog & b_in.dig;
      b_lvl_out = (b_in.oe & b_in.analog) ? b_in.level : 6'h00;
   end
endmodule

/* File: dv/test_signal_router_tb.sv */
`timescale 1ns/100ps
module test_signal_router_tb;
   logic clk, rst_n, aw_v, w_v, b_rdy, ar_v, r_rdy, raw, stb, subc, take;
   logic aw_r, w_r, b_v, ar_r, r_v, act, pbit, a_dig, b_dig, e, pv, ce;
   logic [7:0] aw_a, ar_a;
   logic [31:0] w_d, rdata, rd;
   logic [3:0] w_s;
   logic [1:0] bresp, rresp, rs;
   logic [5:0] bus, a_lvl, b_lvl, lv;
   logic [14:0] q;
   tsr_pkg::tsr_rx_s rx;
   tsr_pkg::tsr_ana_s ana;
   tsr_pkg::tsr_kind_e txk, rxk;
   tsr_pkg::tsr_rate_e rate;
   tsr_pkg::tsr_aux_s aux_a, aux_b;
   int n_mismatch = 0;
   int checked = 0;
   int cnt;

   tsr_router tsr_router_inst (
      .SYS_CLK_IN(clk), .RESETN_IN(rst_n), .CE_IN(ce),
      .S_AXI_AWADDR_IN(aw_a), .S_AXI_AWVALID_IN(aw_v),
      .S_AXI_AWREADY_OUT(aw_r), .S_AXI_WDATA_IN(w_d), .S_AXI_WSTRB_IN(w_s),
      .S_AXI_WVALID_IN(w_v), .S_AXI_WREADY_OUT(w_r),
      .S_AXI_BRESP_OUT(bresp), .S_AXI_BVALID_OUT(b_v),
      .S_AXI_BREADY_IN(b_rdy), .S_AXI_ARADDR_IN(ar_a),
      .S_AXI_ARVALID_IN(ar_v), .S_AXI_ARREADY_OUT(ar_r),
      .S_AXI_RDATA_OUT(rdata), .S_AXI_RRESP_OUT(rresp),
      .S_AXI_RVALID_OUT(r_v), .S_AXI_RREADY_IN(r_rdy),
      .OSC_RAW_IN(raw), .OSC_STABLE_IN(stb), .RX_SIG_IN(rx), .ANA_IN(ana),
      .SUBCARRIER_IN(subc), .TX_KIND_IN(txk), .RX_KIND_IN(rxk),
      .RATE_IN(rate), .TX_BIT_TAKE_IN(take), .TEST_BUS_OUT(bus),
      .AUX_A_OUT(aux_a), .AUX_B_OUT(aux_b), .PRBS_ACTIVE_OUT(act),
      .PRBS_BIT_OUT(pbit)
   );

   tsr_meter tsr_meter_inst (
      .a_in(aux_a), .b_in(aux_b), .a_dig_out(a_dig), .a_lvl_out(a_lvl),
      .b_dig_out(b_dig), .b_lvl_out(b_lvl)
   );

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   task automatic chk(input string nm, input logic [31:0] seen,
         input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("FAIL %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic close_out();
      if (n_mismatch == 0 && checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d,
         input logic [3:0] s);
      aw_a <= a;
      w_d <= {24'h0, d};
      w_s <= s;
      aw_v <= 1'b1;
      w_v <= 1'b1;
      b_rdy <= 1'b1;
      do begin
         @(posedge clk);
         if (aw_r) aw_v <= 1'b0;
         if (w_r) w_v <= 1'b0;
      end while (!b_v);
      rs = bresp;
      b_rdy <= 1'b0;
      @(posedge clk);
   endtask

   task automatic cfg(input logic [7:0] a, input logic [7:0] d);
      wr(a, d, 4'hf);
   endtask

   task automatic rd_reg(input logic [7:0] a);
      ar_a <= a;
      ar_v <= 1'b1;
      r_rdy <= 1'b1;
      do begin
         @(posedge clk);
         if (ar_r) ar_v <= 1'b0;
      end while (!r_v);
      rd = rdata;
      rs = rresp;
      r_rdy <= 1'b0;
      @(posedge clk);
   endtask

   initial begin
      rst_n = 1'b0;
      {aw_v, w_v, b_rdy, ar_v, r_rdy, raw, stb, subc, take} = '0;
      ce = 1'b1;
      aw_a = 8'h00;
      ar_a = 8'h00;
      w_d = 32'h0;
      w_s = 4'h0;
      rx = '0;
      ana = {6'h11, 6'h22, 6'h33, 6'h05};
      txk = tsr_pkg::KIND_IDLE;
      rxk = tsr_pkg::KIND_IDLE;
      rate = tsr_pkg::RATE_106;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      chk("aux_oe_rst", 32'({aux_a.oe, aux_b.oe}), 32'h0);
      for (int i = 0; i < 8; i++) begin
         rd_reg(8'(i * 4));
         chk("reg_rst", rd, 32'h0);
         chk("rresp", 32'(rs), (i == 7) ? 32'h2 : 32'h0);
      end
      wr(8'h20, 8'h11, 4'hf);
      chk("bresp_unmapped", 32'(rs), 32'(tsr_pkg::RESP_SLVERR));
      wr(8'h02, 8'h11, 4'hf);
      chk("bresp_unaligned", 32'(rs), 32'(tsr_pkg::RESP_SLVERR));
      wr(tsr_pkg::OFS_ANALOG, 8'h11, 4'h0);
      rd_reg(tsr_pkg::OFS_ANALOG);
      chk("strobe_off", rd, 32'h0);
      cfg(tsr_pkg::OFS_LEVEL_A, 8'h2a);
      cfg(tsr_pkg::OFS_LEVEL_B, 8'h15);
      subc <= 1'b1;
      for (int c = 0; c < 16; c++) begin
         cfg(tsr_pkg::OFS_ANALOG, {4'(c), 4'(c)});
         repeat (4) @(posedge clk);
         case (c)
            1: lv = 6'h2a;
            2: lv = 6'h11;
            4: lv = 6'h22;
            5: lv = 6'h33;
            6: lv = 6'h05;
            default: lv = 6'h00;
         endcase
         e = (c == 1) || (c == 2) || (c > 3 && c < 7) || (c > 9);
         chk("a_oe", 32'(aux_a.oe), 32'(e));
         chk("a_lvl", 32'(a_lvl), 32'(lv));
         chk("a_dig", 32'(a_dig), 32'(c == 10 || c == 14));
         chk("b_oe", 32'(aux_b.oe), 32'(e));
         chk("b_lvl", 32'(b_lvl), (c == 1) ? 32'h15 : 32'(lv));
         chk("b_dig", 32'(b_dig), 32'(c == 10 || c == 14));
      end
      cfg(tsr_pkg::OFS_ANALOG, 8'h24);
      repeat (3) @(posedge clk);
      chk("nibble_a", 32'(a_lvl), 32'h11);
      chk("nibble_b", 32'(b_lvl), 32'h22);
      cfg(tsr_pkg::OFS_ANALOG, 8'h11);
      for (int v = 0; v < 64; v += 63) begin
         cfg(tsr_pkg::OFS_LEVEL_A, 8'(v));
         repeat (3) @(posedge clk);
         chk("level_a", 32'(a_lvl), 32'(v));
      end
      cfg(tsr_pkg::OFS_ANALOG, 8'hcd);
      for (int r = 0; r < 4; r++) begin
         for (int k = 0; k < 5; k++) begin
            rate <= tsr_pkg::tsr_rate_e'(r);
            txk <= tsr_pkg::tsr_kind_e'(k);
            rxk <= tsr_pkg::tsr_kind_e'(k);
            repeat (4) @(posedge clk);
            e = (k == 2) || (k == 4) || (r == 0 && k != 0);
            chk("tx_flag", 32'(a_dig), 32'(e));
            e = (k == 2) || (k == 4) || (r == 0 && k == 3);
            chk("rx_flag", 32'(b_dig), 32'(e));
         end
      end
      // Enable low must freeze the flags through the kind change
      ce <= 1'b0;
      txk <= tsr_pkg::KIND_IDLE;
      rxk <= tsr_pkg::KIND_IDLE;
      repeat (4) @(posedge clk);
      chk("ce_hold", 32'({a_dig, b_dig}), 32'h3);
      ce <= 1'b1;
      cfg(tsr_pkg::OFS_SEL_TWO, {3'h0, tsr_pkg::GRP_RECEIVER});
      cfg(tsr_pkg::OFS_SEL_ONE, 8'h06);
      cfg(tsr_pkg::OFS_ANALOG, 8'hff);
      for (int i = 0; i < 4; i++) begin
         rx <= {i[0], 4'b1011};
         rate <= i[1] ? tsr_pkg::RATE_212 : tsr_pkg::RATE_106;
         repeat (6) @(posedge clk);
         chk("rx_bus", 32'(bus), 32'({i[0], ~i[1], 4'b0110}));
         chk("bus_bit", 32'(a_dig & b_dig), 32'(i[0]));
      end
      cfg(tsr_pkg::OFS_SEL_TWO, {3'h0, tsr_pkg::GRP_OSC});
      stb <= 1'b1;
      cnt = 0;
      pv = bus[4];
      for (int i = 0; i < 130; i++) begin
         raw <= i[1];
         @(posedge clk);
         if (bus[4] !== pv) cnt++;
         pv = bus[4];
      end
      chk("osc_div", 32'(cnt > 6 && cnt < 10), 32'h1);
      for (int i = 1; i >= 0; i--) begin
         raw <= i[0];
         repeat (6) @(posedge clk);
         chk("osc_lines", 32'(bus & 6'h2f), 32'({i[0], 1'b0}) | 32'h20);
      end
      // Mode is set before the send command is issued
      for (int m = 1; m < 4; m++) begin
         cfg(tsr_pkg::OFS_SEL_TWO, 8'(m << 5));
         cfg(tsr_pkg::OFS_CMD, 8'h01);
         chk("prbs_on", 32'(act), 32'h1);
         rd_reg(tsr_pkg::OFS_STATUS);
         chk("status_on", rd & 32'h1, 32'h1);
         q = tsr_pkg::PRBS_SEED;
         for (int i = 0; i < 40; i++) begin
            chk("prbs_bit", 32'(pbit), 32'((m == 1) ? q[8] : q[14]));
            take <= 1'b1;
            @(posedge clk);
            take <= 1'b0;
            @(posedge clk);
            q = (m == 1) ? {6'h0, q[7:0], q[8] ^ q[4]}
                         : {q[13:0], q[14] ^ q[13]};
         end
         if (m == 1) cfg(tsr_pkg::OFS_CMD, 8'h02);
         else cfg(tsr_pkg::OFS_SEL_TWO, 8'h00);
         chk("prbs_off", 32'(act), 32'h0);
      end
      cfg(tsr_pkg::OFS_ANALOG, 8'h11);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      chk("aux_oe_rst2", 32'({aux_a.oe, aux_b.oe}), 32'h0);
      rst_n <= 1'b1;
      @(posedge clk);
      rd_reg(tsr_pkg::OFS_ANALOG);
      chk("reg_rst2", rd, 32'h0);
      close_out();
   end

   initial begin
      repeat (20000) @(posedge clk);
      n_mismatch++;
      close_out();
   end
endmodule
